// *** common/sip_defines.svh ***
// Constants of the switch ingress policing block: offsets, fields, timing.
// Assumes a 250 MHz core clock and a three-port switch engine.
//
// Summary of operation
// - Meter and color only while metering enabled
// - Stream per port, priority, or both
// - Per-stream committed rate; shared burst sizes
// - Fill committed bucket first, then excess
// - Rate value is 20 ns steps, 0-3 equal
// - Committed bucket sufficient: debit, color green
// - Else excess sufficient: debit, yellow, random discard
// - Neither sufficient: red, drop, no debit
// - Buckets start at 1536 after reset
// - Flow priority without regeneration or class maps
// - Broadcast bytes per 1.72 ms capped per port
// - Flooded traffic limited by broadcast buffer cap
// - Trap IGMP multicast to monitoring port
// - IGMP is IPv4 protocol 2, any encapsulation
// - Never send back to source, except looped IGMP
// - Monitored packet filtered on non-forwarding source port
// - Monitored untagged dropped when tagged-only admit
// - Monitored packet with VID FFFh filtered
// - Monitored non-member filtered under membership checking
// - Many mirrored ports, one sniffer port
// - Receive mirroring copies forwarded packets to sniffer
// - Transmit mirroring copies packets bound for mirrored ports to sniffer
`ifndef SIP_DEFINES_SVH
`define SIP_DEFINES_SVH

`define SIP_CLK_NS            4
`define SIP_CIR_STEP_NS       20
`define SIP_CIR_STEP_CYC      (`SIP_CIR_STEP_NS / `SIP_CLK_NS)
`define SIP_CIR_MIN           13'h0003
`define SIP_BUCKET_INIT       16'h0600
`define SIP_BCAP_INIT         10'h3FF
`define SIP_BCAST_UNIT_SHIFT  6
`define SIP_BCAST_INTERVAL_NS 1720000
`define SIP_IGMP_PROTO        8'h02
`define SIP_VID_RESERVED      12'hFFF
`define SIP_VID_NULL          12'h000

`define SIP_A_METER_CFG 8'h00
`define SIP_A_CBS       8'h04
`define SIP_A_EBS       8'h08
`define SIP_A_RATE      8'h0C
`define SIP_A_BTHROT    8'h10
`define SIP_A_BCAP      8'h14
`define SIP_A_GCFG      8'h18
`define SIP_A_MIRROR    8'h1C
`define SIP_A_DSCP      8'h20
`define SIP_A_RED_CNT   8'h24
`define SIP_A_THR_CNT   8'h28

`define SIP_F_EN        0
`define SIP_F_MODE      2:1
`define SIP_F_BKT       15:0
`define SIP_F_STREAM    4:0
`define SIP_F_RATE      20:8
`define SIP_F_THR_LVL   23:0
`define SIP_F_THR_EN    26:24
`define SIP_F_BCAP      9:0
`define SIP_F_IGMP_EN   0
`define SIP_F_MON_PORT  2:1
`define SIP_F_LOOPBACK  3
`define SIP_F_VLAN_EN   4
`define SIP_F_MEMB_CHK  5
`define SIP_F_ADMIT_NM  6
`define SIP_F_TAG_ONLY  9:7
`define SIP_F_STP_OVR   12:10
`define SIP_F_PRI_DSCP  13
`define SIP_F_PRI_PREC  14
`define SIP_F_PRI_VLAN  15
`define SIP_F_DEF_PRI   24:16
`define SIP_F_RX_EN     0
`define SIP_F_TX_EN     1
`define SIP_F_MIRRORED  4:2
`define SIP_F_SNIFFER   6:5
`define SIP_F_MIR_FILT  7
`define SIP_F_DSCP_IDX  5:0
`define SIP_F_DSCP_PRI  10:8

`endif

// *** common/sip_pkg.sv ***
// Types shared by the ingress policing modules.
// Assumes sip_defines.svh supplies the numeric constants.
package sip_pkg;
  typedef enum logic [1:0] {
    SIP_GREEN  = 2'h0,
    SIP_YELLOW = 2'h1,
    SIP_RED    = 2'h3
  } sip_color_t;
  typedef enum logic [1:0] {
    SIP_MODE_PORT  = 2'h0,
    SIP_MODE_PRIO  = 2'h1,
    SIP_MODE_BOTH  = 2'h2
  } sip_mode_t;
  typedef logic [4:0]  sip_stream_t;
  typedef logic [12:0] sip_rate_t;
  typedef logic [15:0] sip_bkt_t;
  typedef logic [11:0] sip_len_t;
endpackage

// *** common/sip_meter_if.sv ***
// Link between the policing core and its token-bucket meter.
// Assumes both ends share one clock; the color answer is combinational.
`timescale 1ns/100ps
interface sip_meter_if;
  import sip_pkg::*;
  logic        req_valid;
  sip_stream_t req_stream;
  sip_len_t    req_len;
  sip_color_t  res_color;
  sip_bkt_t    committed_burst_size;
  sip_bkt_t    excess_burst_size;
  logic        rate_wr;
  sip_stream_t rate_idx;
  sip_rate_t   rate_val;
  sip_rate_t   rate_rd;
  modport meter (input req_valid, req_stream, req_len, committed_burst_size, excess_burst_size,
                 rate_wr, rate_idx, rate_val,
                 output res_color, rate_rd);
  modport core (output req_valid, req_stream, req_len, committed_burst_size, excess_burst_size,
                rate_wr, rate_idx, rate_val,
                input res_color, rate_rd);
endinterface // sip_meter_if

// *** core/sip_meter.sv ***
// Per-stream two-bucket meter with committed-rate token crediting.
// Assumes at most one packet request per cycle from the core.
`timescale 1ns/100ps
`include "sip_defines.svh"
module sip_meter import sip_pkg::*; #(
  parameter int P_STREAMS = 24
) (
  input wire logic   i_ref_clk,
  input wire logic   i_rstn,
  sip_meter_if.meter mif
);
  if (P_STREAMS < 24 || P_STREAMS > 32) begin : g_chk
    $error("sip_meter: P_STREAMS must be 24..32");
  end

  sip_bkt_t  c_all [P_STREAMS];
  sip_bkt_t  e_all [P_STREAMS];
  sip_rate_t r_all [P_STREAMS];

  for (genvar s = 0; s < P_STREAMS; s++) begin : g_str
    sip_rate_t   rate_q;
    logic [15:0] div_q;
    sip_bkt_t    c_q;
    sip_bkt_t    e_q;
    sip_rate_t   eff;
    logic [15:0] per;
    logic        tick, c_cr, e_cr, hit;
    assign eff  = (rate_q < `SIP_CIR_MIN) ? `SIP_CIR_MIN : rate_q;
    assign per  = 16'(({3'h0, eff} + 16'h0001) * `SIP_CIR_STEP_CYC);
    assign tick = (div_q >= per - 16'h0001);
    assign c_cr = tick && (c_q < mif.committed_burst_size);
    assign e_cr = tick && !(c_q < mif.committed_burst_size) && (e_q < mif.excess_burst_size);
    assign hit  = mif.req_valid && (mif.req_stream == sip_stream_t'(s));
    assign c_all[s] = c_q;
    assign e_all[s] = e_q;
    assign r_all[s] = rate_q;
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) rate_q <= 13'h0000;
      else if (mif.rate_wr && mif.rate_idx == sip_stream_t'(s))
        rate_q <= mif.rate_val;
    end
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) div_q <= 16'h0000;
      else div_q <= tick ? 16'h0000 : div_q + 16'h0001;
    end
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
        c_q <= `SIP_BUCKET_INIT;
        e_q <= `SIP_BUCKET_INIT;
      end else begin
        c_q <= c_q + sip_bkt_t'(c_cr) -
               ((hit && mif.res_color == SIP_GREEN) ? 16'(mif.req_len)
                                                    : 16'h0000);
        e_q <= e_q + sip_bkt_t'(e_cr) -
               ((hit && mif.res_color == SIP_YELLOW) ? 16'(mif.req_len)
                                                     : 16'h0000);
      end
    end
  end

  always_comb begin
    if (32'(mif.req_stream) >= P_STREAMS) mif.res_color = SIP_RED;
    else if (c_all[mif.req_stream] >= 16'(mif.req_len))
      mif.res_color = SIP_GREEN;
    else if (e_all[mif.req_stream] >= 16'(mif.req_len))
      mif.res_color = SIP_YELLOW;
    else mif.res_color = SIP_RED;
  end
  assign mif.rate_rd = (32'(mif.rate_idx) < P_STREAMS) ?
                       r_all[mif.rate_idx] : 13'h0000;
endmodule // sip_meter

// *** core/sip_bcast_throttle.sv ***
// Per-port broadcast byte budget renewed every throttle interval.
// Assumes one packet verdict per cycle; drop answer is combinational.
`timescale 1ns/100ps
`include "sip_defines.svh"
module sip_bcast_throttle import sip_pkg::*; #(
  parameter int P_PORTS        = 3,
  parameter int P_INTERVAL_CYC = `SIP_BCAST_INTERVAL_NS / `SIP_CLK_NS
) (
  input  wire logic               i_ref_clk,
  input  wire logic               i_rstn,
  input  wire logic [P_PORTS*8-1:0] i_level,
  input  wire logic [P_PORTS-1:0] i_en,
  input  wire logic               i_pkt_valid,
  input  wire logic [1:0]         i_pkt_port,
  input  wire sip_len_t           i_pkt_len,
  input  wire logic               i_pkt_bcast,
  output logic                    o_drop
);
  if (P_PORTS > 4 || P_INTERVAL_CYC < 2) begin : g_chk
    $error("sip_bcast_throttle: unsupported parameters");
  end
  logic [31:0]        ivl_q;
  logic               ivl_end;
  logic [P_PORTS-1:0] drop_p;
  assign ivl_end = (ivl_q == 32'(P_INTERVAL_CYC - 1));
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) ivl_q <= 32'h0000_0000;
    else ivl_q <= ivl_end ? 32'h0000_0000 : ivl_q + 32'h0000_0001;
  end
  for (genvar p = 0; p < P_PORTS; p++) begin : g_port
    logic [15:0] used_q;
    logic [15:0] budget;
    logic        hit;
    assign budget = 16'(i_level[p*8 +: 8]) << `SIP_BCAST_UNIT_SHIFT;
    assign hit = i_pkt_valid && i_pkt_bcast && i_en[p] &&
                 (i_pkt_port == 2'(p));
    assign drop_p[p] = hit && (used_q + 16'(i_pkt_len) > budget);
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) used_q <= 16'h0000;
      else if (ivl_end) used_q <= 16'h0000;
      else if (hit && !drop_p[p]) used_q <= used_q + 16'(i_pkt_len);
    end
  end
  assign o_drop = |drop_p;
endmodule // sip_bcast_throttle

// *** core/sip_top.sv ***
// Ingress policing top: meter, priority, throttling, IGMP trap, mirroring.
// Assumes a parsed packet descriptor arrives as a one-cycle pulse from the
// receive MACs' lookup logic on the same clock; the verdict follows one
// cycle later toward the forwarding logic and buffer manager.
`timescale 1ns/100ps
`include "sip_defines.svh"
module sip_top import sip_pkg::*; #(
  parameter int P_PORTS            = 3,
  parameter int P_PRIOS            = 8,
  parameter int P_BCAST_INTERVAL_CYC =
    `SIP_BCAST_INTERVAL_NS / `SIP_CLK_NS
) (
  input  wire logic        i_ref_clk,
  input  wire logic        i_rstn,
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  input  wire logic        i_pkt_valid,
  input  wire logic [1:0]  i_pkt_port,
  input  wire sip_len_t    i_pkt_len,
  input  wire logic        i_pkt_ipv4,
  input  wire logic        i_pkt_ipv6,
  input  wire logic [7:0]  i_pkt_tos,
  input  wire logic [7:0]  i_pkt_proto,
  input  wire logic        i_pkt_tagged,
  input  wire logic [11:0] i_pkt_vid,
  input  wire logic [2:0]  i_pkt_vlan_pri,
  input  wire logic        i_pkt_bcast,
  input  wire logic        i_pkt_mcast,
  input  wire logic        i_pkt_unknown_uc,
  input  wire logic [2:0]  i_pkt_dest,
  input  wire logic        i_pkt_filtered,
  input  wire logic        i_vlan_member,
  input  wire logic [2:0]  i_port_forwarding,
  input  wire logic [9:0]  i_bcast_buf_used,
  output logic             o_res_valid,
  output logic [2:0]       o_res_dest,
  output sip_color_t       o_res_color,
  output logic             o_res_drop,
  output logic             o_res_random_discard,
  output logic [2:0]       o_res_prio,
  output logic             o_res_monitored
);
  if (P_PORTS != 3 || P_PRIOS != 8 || P_BCAST_INTERVAL_CYC < 2) begin : g_chk
    $error("sip_top: only 3 ports, 8 priorities and interval >= 2");
  end

  // Configuration registers
  logic        meter_en_q;
  sip_mode_t   meter_mode_q;
  sip_bkt_t    cbs_q;
  sip_bkt_t    ebs_q;
  sip_stream_t rate_sel_q;
  sip_rate_t   rate_val_q;
  logic        rate_wr_q;
  logic [23:0] thr_level_q;
  logic [2:0]  thr_en_q;
  logic [9:0]  bcap_q;
  logic [31:0] gcfg_q;
  logic [7:0]  mirror_q;
  logic [5:0]  dscp_idx_q;
  logic [2:0]  dscp_map_q [64];
  logic [15:0] red_cnt_q;
  logic [15:0] thr_cnt_q;

  sip_meter_if mif ();

  // Register writes
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      meter_en_q   <= 1'b0;
      meter_mode_q <= SIP_MODE_PORT;
      cbs_q        <= `SIP_BUCKET_INIT;
      ebs_q        <= `SIP_BUCKET_INIT;
      thr_level_q  <= 24'h000000;
      thr_en_q     <= 3'h0;
      bcap_q       <= `SIP_BCAP_INIT;
      gcfg_q       <= 32'h0000_0000;
      mirror_q     <= 8'h00;
    end else if (i_wr) begin
      case (i_addr)
        `SIP_A_METER_CFG: begin
          meter_en_q   <= i_wdata[`SIP_F_EN];
          meter_mode_q <= sip_mode_t'(i_wdata[`SIP_F_MODE]);
        end
        `SIP_A_CBS:    cbs_q <= i_wdata[`SIP_F_BKT];
        `SIP_A_EBS:    ebs_q <= i_wdata[`SIP_F_BKT];
        `SIP_A_BTHROT: begin
          thr_level_q <= i_wdata[`SIP_F_THR_LVL];
          thr_en_q    <= i_wdata[`SIP_F_THR_EN];
        end
        `SIP_A_BCAP:   bcap_q <= i_wdata[`SIP_F_BCAP];
        `SIP_A_GCFG:   gcfg_q <= i_wdata;
        `SIP_A_MIRROR: mirror_q <= i_wdata[7:0];
        default: ;
      endcase
    end
  end

  // Committed rate table writes go to the meter one cycle later
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rate_sel_q <= 5'h00;
      rate_val_q <= 13'h0000;
      rate_wr_q  <= 1'b0;
    end else begin
      rate_wr_q <= i_wr && (i_addr == `SIP_A_RATE);
      if (i_wr && i_addr == `SIP_A_RATE) begin
        rate_sel_q <= i_wdata[`SIP_F_STREAM];
        rate_val_q <= i_wdata[`SIP_F_RATE];
      end
    end
  end

  // Priority map; contents are undefined until software fills them
  always_ff @(posedge i_ref_clk) begin
    if (i_wr && i_addr == `SIP_A_DSCP)
      dscp_map_q[i_wdata[`SIP_F_DSCP_IDX]] <= i_wdata[`SIP_F_DSCP_PRI];
  end
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) dscp_idx_q <= 6'h00;
    else if (i_wr && i_addr == `SIP_A_DSCP)
      dscp_idx_q <= i_wdata[`SIP_F_DSCP_IDX];
  end

  // Field views of the global ingress and mirroring settings
  logic       igmp_en, loopback, vlan_en, memb_chk, admit_nm;
  logic [1:0] mon_port, sniffer;
  logic [2:0] tag_only, stp_ovr, mirrored;
  logic [8:0] def_pri;
  logic       pri_dscp, pri_prec, pri_vlan;
  logic       rx_mir, tx_mir, mir_filt;
  assign igmp_en  = gcfg_q[`SIP_F_IGMP_EN];
  assign mon_port = gcfg_q[`SIP_F_MON_PORT];
  assign loopback = gcfg_q[`SIP_F_LOOPBACK];
  assign vlan_en  = gcfg_q[`SIP_F_VLAN_EN];
  assign memb_chk = gcfg_q[`SIP_F_MEMB_CHK];
  assign admit_nm = gcfg_q[`SIP_F_ADMIT_NM];
  assign tag_only = gcfg_q[`SIP_F_TAG_ONLY];
  assign stp_ovr  = gcfg_q[`SIP_F_STP_OVR];
  assign pri_dscp = gcfg_q[`SIP_F_PRI_DSCP];
  assign pri_prec = gcfg_q[`SIP_F_PRI_PREC];
  assign pri_vlan = gcfg_q[`SIP_F_PRI_VLAN];
  assign def_pri  = gcfg_q[`SIP_F_DEF_PRI];
  assign rx_mir   = mirror_q[`SIP_F_RX_EN];
  assign tx_mir   = mirror_q[`SIP_F_TX_EN];
  assign mirrored = mirror_q[`SIP_F_MIRRORED];
  assign sniffer  = mirror_q[`SIP_F_SNIFFER];
  assign mir_filt = mirror_q[`SIP_F_MIR_FILT];

  // Ingress flow priority, bypassing regeneration and class maps
  logic [2:0] flow_pri;
  always_comb begin
    if ((i_pkt_ipv4 || i_pkt_ipv6) && pri_dscp)
      flow_pri = dscp_map_q[i_pkt_tos[7:2]];
    else if (i_pkt_ipv4 && pri_prec)
      flow_pri = i_pkt_tos[7:5];
    else if (i_pkt_tagged && pri_vlan)
      flow_pri = i_pkt_vlan_pri;
    else
      flow_pri = def_pri[i_pkt_port*3 +: 3];
  end

  // Stream selection
  sip_stream_t stream;
  always_comb begin
    case (meter_mode_q)
      SIP_MODE_PORT: stream = sip_stream_t'(i_pkt_port);
      SIP_MODE_PRIO: stream = sip_stream_t'(flow_pri);
      default:       stream = {i_pkt_port, flow_pri};
    endcase
  end

  assign mif.req_valid  = i_pkt_valid && meter_en_q;
  assign mif.req_stream = stream;
  assign mif.req_len    = i_pkt_len;
  assign mif.committed_burst_size        = cbs_q;
  assign mif.excess_burst_size        = ebs_q;
  assign mif.rate_wr    = rate_wr_q;
  assign mif.rate_idx   = rate_sel_q;
  assign mif.rate_val   = rate_val_q;

  sip_meter #(
    .P_STREAMS (P_PORTS * P_PRIOS)
  ) u_meter (
    .i_ref_clk (i_ref_clk),
    .i_rstn    (i_rstn),
    .mif       (mif.meter)
  );

  logic thr_drop;
  sip_bcast_throttle #(
    .P_PORTS        (P_PORTS),
    .P_INTERVAL_CYC (P_BCAST_INTERVAL_CYC)
  ) u_throttle (
    .i_ref_clk   (i_ref_clk),
    .i_rstn      (i_rstn),
    .i_level     (thr_level_q),
    .i_en        (thr_en_q),
    .i_pkt_valid (i_pkt_valid),
    .i_pkt_port  (i_pkt_port),
    .i_pkt_len   (i_pkt_len),
    .i_pkt_bcast (i_pkt_bcast),
    .o_drop      (thr_drop)
  );

  // Forwarding verdict
  sip_color_t color;
  logic       igmp, monitored, mon_filt, cap_drop, fwd_filt, red_drop;
  logic       untag_like;
  logic [2:0] src_bit, base_dest, mir_dest, final_dest;
  assign color = meter_en_q ? mif.res_color : SIP_GREEN;
  assign red_drop = (color == SIP_RED);
  assign src_bit = 3'h1 << i_pkt_port;
  assign igmp = i_pkt_ipv4 && (i_pkt_proto == `SIP_IGMP_PROTO) &&
                i_pkt_mcast;
  assign monitored = igmp_en && igmp;
  assign untag_like = !i_pkt_tagged || (i_pkt_vid == `SIP_VID_NULL);
  assign mon_filt =
      (!i_port_forwarding[i_pkt_port] && !stp_ovr[i_pkt_port])
   || (vlan_en && untag_like && tag_only[i_pkt_port])
   || (vlan_en && i_pkt_tagged && i_pkt_vid == `SIP_VID_RESERVED)
   || (vlan_en && memb_chk && !admit_nm && !i_vlan_member);
  assign cap_drop = (i_pkt_bcast || i_pkt_mcast || i_pkt_unknown_uc) &&
                    (i_bcast_buf_used >= bcap_q);
  assign fwd_filt = monitored ? mon_filt
                              : (i_pkt_filtered || thr_drop);

  always_comb begin
    if (monitored)
      base_dest = 3'h1 << mon_port;
    else
      base_dest = i_pkt_dest & ~src_bit;
    if (fwd_filt || red_drop || (cap_drop && !monitored))
      base_dest = 3'h0;
  end

  always_comb begin
    mir_dest = base_dest;
    if (rx_mir && mirrored[i_pkt_port] && !red_drop &&
        (base_dest != 3'h0 || (mir_filt && fwd_filt)))
      mir_dest = mir_dest | (3'h1 << sniffer);
    if (tx_mir && (base_dest & mirrored) != 3'h0)
      mir_dest = mir_dest | (3'h1 << sniffer);
  end

  always_comb begin
    final_dest = mir_dest;
    if (!(monitored && loopback))
      final_dest = mir_dest & ~src_bit;
  end

  // Verdict outputs
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_res_valid          <= 1'b0;
      o_res_dest           <= 3'h0;
      o_res_color          <= SIP_GREEN;
      o_res_drop           <= 1'b0;
      o_res_random_discard <= 1'b0;
      o_res_prio           <= 3'h0;
      o_res_monitored      <= 1'b0;
    end else begin
      o_res_valid          <= i_pkt_valid;
      o_res_dest           <= i_pkt_valid ? final_dest : 3'h0;
      o_res_color          <= i_pkt_valid ? color : SIP_GREEN;
      o_res_drop           <= i_pkt_valid && (final_dest == 3'h0);
      o_res_random_discard <= i_pkt_valid && (color == SIP_YELLOW);
      o_res_prio           <= i_pkt_valid ? flow_pri : 3'h0;
      o_res_monitored      <= i_pkt_valid && monitored;
    end
  end

  // Drop statistics, saturating
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      red_cnt_q <= 16'h0000;
      thr_cnt_q <= 16'h0000;
    end else begin
      if (i_pkt_valid && red_drop && red_cnt_q != 16'hFFFF)
        red_cnt_q <= red_cnt_q + 16'h0001;
      if (i_pkt_valid && thr_drop && !monitored && thr_cnt_q != 16'hFFFF)
        thr_cnt_q <= thr_cnt_q + 16'h0001;
    end
  end

  // Read data stands only in the cycle after the read strobe
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (i_addr)
      `SIP_A_METER_CFG: begin
        rd_mux[`SIP_F_EN]   = meter_en_q;
        rd_mux[`SIP_F_MODE] = meter_mode_q;
      end
      `SIP_A_CBS:    rd_mux[`SIP_F_BKT] = cbs_q;
      `SIP_A_EBS:    rd_mux[`SIP_F_BKT] = ebs_q;
      `SIP_A_RATE: begin
        rd_mux[`SIP_F_STREAM] = rate_sel_q;
        rd_mux[`SIP_F_RATE]   = mif.rate_rd;
      end
      `SIP_A_BTHROT: begin
        rd_mux[`SIP_F_THR_LVL] = thr_level_q;
        rd_mux[`SIP_F_THR_EN]  = thr_en_q;
      end
      `SIP_A_BCAP:    rd_mux[`SIP_F_BCAP] = bcap_q;
      `SIP_A_GCFG:    rd_mux = gcfg_q;
      `SIP_A_MIRROR:  rd_mux[7:0] = mirror_q;
      `SIP_A_DSCP: begin
        rd_mux[`SIP_F_DSCP_IDX] = dscp_idx_q;
        rd_mux[`SIP_F_DSCP_PRI] = dscp_map_q[dscp_idx_q];
      end
      `SIP_A_RED_CNT: rd_mux[15:0] = red_cnt_q;
      `SIP_A_THR_CNT: rd_mux[15:0] = thr_cnt_q;
      default:        rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) o_rdata <= 32'h0000_0000;
    else o_rdata <= i_rd ? rd_mux : 32'h0000_0000;
  end
endmodule // sip_top

// *** testbench/sip_chk.sv ***
// Checker on the ports of the policing top, bound into sip_top.
// Assumes one clock and the active-low asynchronous reset.
`timescale 1ns/100ps
module sip_chk import sip_pkg::*; (
  input wire logic        i_ref_clk,
  input wire logic        i_rstn,
  input wire logic        i_rd,
  input wire logic        i_pkt_valid,
  input wire logic [1:0]  i_pkt_port,
  input wire logic [31:0] o_rdata,
  input wire logic        o_res_valid,
  input wire logic [2:0]  o_res_dest,
  input wire sip_color_t  o_res_color,
  input wire logic        o_res_drop,
  input wire logic        o_res_random_discard,
  input wire logic        o_res_monitored
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);
  property p_ans; i_pkt_valid |=> o_res_valid; endproperty
  a_ans: assert property (p_ans) else $error("verdict missing");
  property p_one; o_res_valid |-> $past(i_pkt_valid); endproperty
  a_one: assert property (p_one) else $error("stray verdict");
  property p_red; o_res_valid && o_res_color == SIP_RED
    |-> o_res_drop && o_res_dest == 3'h0; endproperty
  a_red: assert property (p_red) else $error("red forwarded");
  property p_yel; o_res_valid && o_res_color == SIP_YELLOW
    |-> o_res_random_discard; endproperty
  a_yel: assert property (p_yel) else $error("yellow kept");
  property p_rdd; o_res_random_discard |-> o_res_color == SIP_YELLOW;
  endproperty
  a_rdd: assert property (p_rdd) else $error("discard not yellow");
  property p_drp; o_res_valid |-> o_res_drop == (o_res_dest == 3'h0);
  endproperty
  a_drp: assert property (p_drp) else $error("drop mismatch");
  property p_src; i_pkt_valid ##1 !o_res_monitored
    |-> !o_res_dest[$past(i_pkt_port)]; endproperty
  a_src: assert property (p_src) else $error("sent to source");
  property p_rd; o_rdata != 32'h0 |-> $past(i_rd); endproperty
  a_rd: assert property (p_rd) else $error("stray read data");
  c_yel: cover property (o_res_valid && o_res_color == SIP_YELLOW);
  c_red: cover property (o_res_valid && o_res_color == SIP_RED);
  c_mon: cover property (o_res_monitored);
endmodule // sip_chk
bind sip_top sip_chk chk_u (.i_ref_clk, .i_rstn, .i_rd, .i_pkt_valid,
  .i_pkt_port, .o_rdata, .o_res_valid, .o_res_dest, .o_res_color,
  .o_res_drop, .o_res_random_discard, .o_res_monitored);

// *** testbench/sip_mac_model.sv ***
// Receive MAC and buffer manager stand-in issuing packet descriptors.
// Assumes send is called from a bench clocked by i_ref_clk.
`timescale 1ns/100ps
module sip_mac_model (
  input  wire logic   i_ref_clk,
  output logic        o_valid,
  output logic [1:0]  o_port,
  output logic [11:0] o_len,
  output logic [2:0]  o_dest,
  output logic [1:0]  o_kind,
  output logic [7:0]  o_proto,
  output logic [9:0]  o_used
);
  initial {o_valid, o_port, o_len, o_dest, o_kind, o_proto, o_used} = '0;
  task automatic send(input logic [1:0] p, input logic [11:0] n,
    input logic [2:0] d, input logic [1:0] k, input logic [7:0] r);
    @(posedge i_ref_clk);
    {o_valid, o_port, o_len, o_dest, o_kind, o_proto} <= {1'h1, p, n, d, k, r};
    @(posedge i_ref_clk);
    // Released length and protocol carry junk, not the last value; port, dest and kind keep it
    {o_valid, o_len, o_proto} <= {1'h0, ~n, ~r};
  endtask
endmodule // sip_mac_model

// *** testbench/tb.sv ***
// Self-checking bench for the ingress policing top.
// Assumes sip_chk is bound in; throttle interval cut to 200 cycles.
`timescale 1ns/100ps
module tb;
  import sip_pkg::*;
  logic i_ref_clk = 1'h0, i_rstn = 1'h0, i_wr = 1'h0, i_rd = 1'h0;
  logic [7:0] i_addr = 8'h00, i_pkt_tos = 8'h00, i_pkt_proto;
  logic [31:0] i_wdata = 32'h0, o_rdata;
  logic i_pkt_valid, i_pkt_bcast, i_pkt_mcast, i_pkt_tagged = 1'h0;
  logic [1:0] i_pkt_port;
  sip_len_t i_pkt_len;
  logic [2:0] i_pkt_dest, i_port_forwarding = 3'h7, i_pkt_vlan_pri = 3'h0;
  logic [11:0] i_pkt_vid = 12'h000;
  logic [9:0] i_bcast_buf_used;
  logic i_pkt_ipv4 = 1'h1, i_pkt_ipv6 = 1'h0, i_pkt_unknown_uc = 1'h0;
  logic i_pkt_filtered = 1'h0, i_vlan_member = 1'h1;
  logic o_res_valid, o_res_drop, o_res_random_discard, o_res_monitored;
  logic [2:0] o_res_dest, o_res_prio;
  sip_color_t o_res_color;
  int bad_count = 0, checked = 0;
  sip_top #(.P_BCAST_INTERVAL_CYC(200)) dut_u (.*);
  sip_mac_model mac_u (.i_ref_clk, .o_valid(i_pkt_valid),
    .o_port(i_pkt_port), .o_len(i_pkt_len), .o_dest(i_pkt_dest),
    .o_kind({i_pkt_bcast, i_pkt_mcast}), .o_proto(i_pkt_proto),
    .o_used(i_bcast_buf_used));
  always #2 i_ref_clk = ~i_ref_clk;
  task automatic cmp(input string s, input logic [31:0] e, g);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    {i_wr, i_addr, i_wdata} <= {1'h1, a, d};
    @(posedge i_ref_clk);
    i_wr <= 1'h0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    @(posedge i_ref_clk);
    {i_rd, i_addr} <= {1'h1, a};
    @(posedge i_ref_clk);
    i_rd <= 1'h0;
    #1 cmp("rdata", e, o_rdata);
  endtask
  // Expected word is {dest, color, drop}; kind is {bcast, mcast}
  task automatic pkt(input logic [1:0] p, input logic [11:0] n,
    input logic [2:0] d, input logic [1:0] k, input logic [7:0] r,
    input logic [5:0] e);
    mac_u.send(p, n, d, k, r);
    #1 cmp("verdict", {26'h0, e},
      {26'h0, o_res_dest, o_res_color, o_res_drop});
  endtask
  task automatic t_meter;
    rchk(8'h14, 32'h0000_03FF);
    rchk(8'hFC, 32'h0);
    wreg(8'h00, 32'h1);
    wreg(8'h0C, 32'h0000_0201);
    rchk(8'h0C, 32'h0000_0201);
    rchk(8'h00, 32'h1);
    pkt(2'h1, 12'h600, 3'h5, 2'h0, 8'h00, 6'h28);
    pkt(2'h1, 12'h600, 3'h5, 2'h0, 8'h00, 6'h2A);
    pkt(2'h1, 12'h600, 3'h5, 2'h0, 8'h00, 6'h07);
    repeat (1200) @(posedge i_ref_clk);
    pkt(2'h1, 12'h046, 3'h5, 2'h0, 8'h00, 6'h07);
    pkt(2'h1, 12'h03C, 3'h5, 2'h0, 8'h00, 6'h28);
    wreg(8'h00, 32'h3);
    pkt(2'h1, 12'h600, 3'h5, 2'h0, 8'h00, 6'h28);
    wreg(8'h00, 32'h5);
    pkt(2'h1, 12'h600, 3'h5, 2'h0, 8'h00, 6'h28);
    wreg(8'h00, 32'h0);
    pkt(2'h1, 12'h600, 3'h5, 2'h0, 8'h00, 6'h28);
  endtask
  task automatic t_igmp;
    wreg(8'h18, 32'h1);
    pkt(2'h1, 12'h040, 3'h6, 2'h1, 8'h02, 6'h08);
    cmp("monitored", 32'h1, {31'h0, o_res_monitored});
    pkt(2'h1, 12'h040, 3'h6, 2'h1, 8'h03, 6'h20);
    wreg(8'h18, 32'h0000_000B);
    pkt(2'h1, 12'h040, 3'h6, 2'h1, 8'h02, 6'h10);
    wreg(8'h18, 32'h0000_0011);
    {i_pkt_tagged, i_pkt_vid} <= {1'h1, 12'hFFF};
    pkt(2'h1, 12'h040, 3'h6, 2'h1, 8'h02, 6'h01);
    {i_pkt_tagged, i_pkt_vid, i_port_forwarding} <= {1'h0, 12'h000, 3'h5};
    wreg(8'h18, 32'h1);
    pkt(2'h1, 12'h040, 3'h6, 2'h1, 8'h02, 6'h01);
    i_port_forwarding <= 3'h7;
    wreg(8'h18, 32'h0000_0111);
    pkt(2'h1, 12'h040, 3'h6, 2'h1, 8'h02, 6'h01);
    wreg(8'h18, 32'h0000_0031);
    i_vlan_member <= 1'h0;
    pkt(2'h1, 12'h040, 3'h6, 2'h1, 8'h02, 6'h01);
    i_vlan_member <= 1'h1;
    wreg(8'h18, 32'h0);
  endtask
  task automatic t_mirror;
    wreg(8'h1C, 32'h0000_0011);
    pkt(2'h2, 12'h040, 3'h2, 2'h0, 8'h00, 6'h18);
    pkt(2'h1, 12'h040, 3'h4, 2'h0, 8'h00, 6'h20);
    wreg(8'h1C, 32'h0000_0012);
    pkt(2'h1, 12'h040, 3'h4, 2'h0, 8'h00, 6'h28);
    wreg(8'h1C, 32'h0000_0091);
    i_pkt_filtered <= 1'h1;
    pkt(2'h2, 12'h040, 3'h2, 2'h0, 8'h00, 6'h08);
    i_pkt_filtered <= 1'h0;
    wreg(8'h1C, 32'h0);
  endtask
  task automatic t_limits;
    wreg(8'h10, 32'h0100_0001);
    pkt(2'h0, 12'h041, 3'h6, 2'h2, 8'h00, 6'h01);
    pkt(2'h0, 12'h040, 3'h6, 2'h2, 8'h00, 6'h30);
    wreg(8'h10, 32'h0);
    wreg(8'h14, 32'h5);
    mac_u.o_used <= 10'h005;
    pkt(2'h1, 12'h040, 3'h5, 2'h1, 8'h00, 6'h01);
    mac_u.o_used <= 10'h004;
    pkt(2'h1, 12'h040, 3'h5, 2'h1, 8'h00, 6'h28);
    i_pkt_tos <= 8'hA0;
    wreg(8'h18, 32'h0038_4000);
    pkt(2'h1, 12'h040, 3'h5, 2'h0, 8'h00, 6'h28);
    cmp("prio", 32'h5, {29'h0, o_res_prio});
    wreg(8'h18, 32'h0038_0000);
    pkt(2'h1, 12'h040, 3'h5, 2'h0, 8'h00, 6'h28);
    cmp("prio", 32'h7, {29'h0, o_res_prio});
  endtask
  task automatic wrap_up;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge i_ref_clk);
    i_rstn <= 1'h1;
    t_meter;
    t_igmp;
    t_mirror;
    t_limits;
    wrap_up;
  end
  initial begin
    repeat (20000) @(posedge i_ref_clk);
    bad_count++;
    wrap_up;
  end
endmodule // tb
